// ---- hw/rca_pkg.sv ----
package rca_pkg;
  localparam int RCA_VAL_W = 16;
  localparam int RCA_TMO_W = 16;
  localparam int RCA_IF_W = 2;
  // Supervision tick period (1 ms units)
  localparam int RCA_TICK_NS = 1000000;
  localparam int RCA_CLK_NS = 25;
  localparam int RCA_TICK_CYC = RCA_TICK_NS / RCA_CLK_NS;
  // Standby acknowledge low phase, least time
  localparam int RCA_ACK_LOW_MS = 50;
  localparam int RCA_ACK_LOW_CYC = (RCA_ACK_LOW_MS * 1000000 + RCA_CLK_NS - 1) / RCA_CLK_NS;
  localparam logic [RCA_TMO_W-1:0] RCA_TMO_RESET = 16'h03E8;
  localparam logic [RCA_VAL_W-1:0] RCA_REF_5V = 16'h1388;
  localparam logic [RCA_VAL_W-1:0] RCA_REF_10V = 16'h2710;
  // Digital source index reserved for the master-slave bus
  localparam logic [RCA_IF_W-1:0] RCA_IF_MSBUS = 2'h3;
  typedef enum logic [1:0] {RCA_LOC_MANUAL, RCA_LOC_DIGITAL, RCA_LOC_ANALOG, RCA_LOC_LOCAL} rca_loc_e;
endpackage

// ---- hw/rca_sup_if.sv ----
`timescale 1ns/100ps
interface rca_sup_if;
  import rca_pkg::*;
  logic run;
  logic msg;
  logic [RCA_TMO_W-1:0] tmo;
  logic expired;
  modport ctl (output run, output msg, output tmo, input expired);
  modport sup (input run, input msg, input tmo, output expired);
endinterface

// ---- hw/rca_supervisor.sv ----
`timescale 1ns/100ps
module rca_supervisor
#(
  parameter int TICK_CYC = rca_pkg::RCA_TICK_CYC
)
(
  input wire logic i_ref_clk,
  input wire logic i_resetn,
  input wire logic i_ce,
  rca_sup_if.sup sup
);
  import rca_pkg::*;
  typedef struct packed {
    logic [31:0] pre;
    logic [RCA_TMO_W-1:0] cnt;
    logic expired;
  } rca_sup_s;
  rca_sup_s s_reg;
  rca_sup_s s_next;

  always_comb
  begin
    s_next = s_reg;
    s_next.expired = 1'b0;
    if (!sup.run)
    begin
      // Idle outside digital remote control
      s_next.pre = '0;
      s_next.cnt = sup.tmo;
    end
    else if (sup.msg)
    begin
      s_next.pre = '0;
      s_next.cnt = sup.tmo;
    end
    else if (s_reg.pre >= 32'(TICK_CYC - 1))
    begin
      s_next.pre = '0;
      if (s_reg.cnt <= 16'h0001)
      begin
        s_next.expired = 1'b1;
        // New value loads at period end, on a message and while idle
        s_next.cnt = sup.tmo;
      end
      else
        s_next.cnt = s_reg.cnt - 16'h0001;
    end
    else
      s_next.pre = s_reg.pre + 32'h1;
  end

  always_ff @(posedge i_ref_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      s_reg.pre <= '0;
      s_reg.cnt <= RCA_TMO_RESET;
      s_reg.expired <= 1'b0;
    end
    else if (i_ce)
      s_reg <= s_next;
  end

  assign sup.expired = s_reg.expired;
endmodule

// ---- hw/rca_arbiter.sv ----
`timescale 1ns/100ps
module rca_arbiter
#(
  parameter int VAL_W = rca_pkg::RCA_VAL_W,
  parameter int TICK_CYC = rca_pkg::RCA_TICK_CYC,
  parameter int ACK_LOW_CYC = rca_pkg::RCA_ACK_LOW_CYC
)
(
  // Clock and reset
  input wire logic i_ref_clk,
  input wire logic i_resetn,
  input wire logic i_ce,
  // Settings
  input wire logic i_allow_remote,
  input wire logic i_state_after_remote_on,
  input wire logic i_range_10v,
  input wire logic [rca_pkg::RCA_TMO_W-1:0] i_sup_timeout,
  // Digital interfaces
  input wire logic i_dig_req_take,
  input wire logic i_dig_req_release,
  input wire logic [rca_pkg::RCA_IF_W-1:0] i_dig_if,
  input wire logic i_dig_msg,
  input wire logic [rca_pkg::RCA_IF_W-1:0] i_dig_msg_if,
  input wire logic i_dig_status_rd,
  input wire logic [rca_pkg::RCA_IF_W-1:0] i_dig_status_if,
  // Analog port
  input wire logic i_remote_select_n,
  input wire logic i_output_standby_input,
  input wire logic [VAL_W-1:0] i_voltage_setpoint_in,
  input wire logic [VAL_W-1:0] i_current_setpoint_in,
  input wire logic [VAL_W-1:0] i_power_setpoint_in,
  input wire logic [VAL_W-1:0] i_resistance_setpoint_in,
  // Local values and limits
  input wire logic [VAL_W-1:0] i_local_u,
  input wire logic [VAL_W-1:0] i_local_i,
  input wire logic [VAL_W-1:0] i_local_p,
  input wire logic [VAL_W-1:0] i_local_r,
  input wire logic [VAL_W-1:0] i_lim_u,
  input wire logic [VAL_W-1:0] i_lim_i,
  input wire logic [VAL_W-1:0] i_lim_p,
  input wire logic [VAL_W-1:0] i_lim_r,
  input wire logic [VAL_W-1:0] i_ovp_thresh,
  // Output state and actual values
  input wire logic i_output_on,
  input wire logic [VAL_W-1:0] i_actual_u_pct,
  input wire logic [VAL_W-1:0] i_actual_i_pct,
  // Control location
  output logic [1:0] o_location,
  output logic [rca_pkg::RCA_IF_W-1:0] o_ctrl_if,
  output logic o_dig_error,
  output logic o_dig_status_ack,
  output logic [1:0] o_dig_status_loc,
  output logic o_sup_expired,
  output logic o_output_off_req,
  output logic o_alarm_ack,
  // Applied values
  output logic [VAL_W-1:0] o_set_u,
  output logic [VAL_W-1:0] o_set_i,
  output logic [VAL_W-1:0] o_set_p,
  output logic [VAL_W-1:0] o_set_r,
  output logic [VAL_W-1:0] o_ovp_applied,
  output logic [VAL_W-1:0] o_vref,
  output logic [VAL_W-1:0] o_voltage_monitor_out,
  output logic [VAL_W-1:0] o_current_monitor_out
);
  import rca_pkg::*;

  typedef struct packed {
    // Control location and owning link
    rca_loc_e loc;
    logic [RCA_IF_W-1:0] ifx;
    // One-cycle answers and pulses
    logic err;
    logic st_ack;
    logic [1:0] st_loc;
    logic expired;
    logic off_req;
    // Standby acknowledge tracking
    logic sb_prev;
    logic [31:0] sb_low;
    logic ack;
    // Applied values and analog pins
    logic [VAL_W-1:0] u;
    logic [VAL_W-1:0] i;
    logic [VAL_W-1:0] p;
    logic [VAL_W-1:0] r;
    logic [VAL_W-1:0] overvoltage_protection;
    logic [VAL_W-1:0] vref;
    logic [VAL_W-1:0] voltage_monitor_out;
    logic [VAL_W-1:0] current_monitor_out;
  } rca_arb_s;

  rca_arb_s s_reg;
  rca_arb_s s_next;
  rca_sup_if sup();

  function automatic logic [VAL_W-1:0] clip(input logic [VAL_W-1:0] v, input logic [VAL_W-1:0] lim);
    if (v > lim)
      clip = lim;
    else
      clip = v;
  endfunction

  // Scale percent (full scale = 2^VAL_W) into millivolts of range
  function automatic logic [VAL_W-1:0] scale(input logic [VAL_W-1:0] pct, input logic [VAL_W-1:0] full);
    logic [2*VAL_W-1:0] prod;
    prod = pct * full;
    scale = prod[2*VAL_W-1:VAL_W];
  endfunction

  logic analog_req;
  logic own_release;
  logic foreign_take;
  logic sb_rise;
  assign analog_req = !i_remote_select_n;
  // Link decode against the current owner
  assign own_release = i_dig_req_release && (i_dig_if == s_reg.ifx);
  assign foreign_take = i_dig_req_take && (i_dig_if != s_reg.ifx);
  assign sb_rise = i_output_standby_input && !s_reg.sb_prev;

  // Watchdog for the controlling link
  rca_supervisor #(.TICK_CYC(TICK_CYC)) u_sup
  (
    .i_ref_clk(i_ref_clk),
    .i_resetn(i_resetn),
    .i_ce(i_ce),
    .sup(sup.sup)
  );

  // Supervision runs only for the controlling digital link
  assign sup.run = (s_reg.loc == RCA_LOC_DIGITAL);
  assign sup.msg = i_dig_msg && (i_dig_msg_if == s_reg.ifx);
  assign sup.tmo = i_sup_timeout;

  always_comb
  begin
    s_next = s_reg;
    s_next.err = 1'b0;
    s_next.expired = 1'b0;
    s_next.off_req = 1'b0;
    s_next.ack = 1'b0;
    // Status answered in every location, from any link
    s_next.st_ack = i_dig_status_rd;
    s_next.st_loc = s_reg.loc;
    case (s_reg.loc)
      // Manual: takeovers from either side accepted
      RCA_LOC_MANUAL:
      begin
        if (!i_allow_remote)
        begin
          s_next.loc = RCA_LOC_LOCAL;
          s_next.err = i_dig_req_take;
        end
        else if (analog_req)
        begin
          s_next.loc = RCA_LOC_ANALOG;
          s_next.err = i_dig_req_take;
        end
        else if (i_dig_req_take)
        begin
          // Master-slave bus enters here like any other link
          s_next.loc = RCA_LOC_DIGITAL;
          s_next.ifx = i_dig_if;
        end
      end
      RCA_LOC_DIGITAL:
      begin
        // Analog select is not looked at here
        if (!i_allow_remote)
        begin
          s_next.loc = RCA_LOC_LOCAL;
        end
        else if (sup.expired)
        begin
          s_next.loc = RCA_LOC_MANUAL;
          s_next.expired = 1'b1;
          s_next.off_req = i_output_on && !i_state_after_remote_on;
        end
        else if (own_release)
        begin
          s_next.loc = RCA_LOC_MANUAL;
        end
        else if (foreign_take)
        begin
          // A second link may not share control
          s_next.err = 1'b1;
        end
      end
      RCA_LOC_ANALOG:
      begin
        // Digital takeovers bounce while the pins rule
        s_next.err = i_dig_req_take;
        if (!i_allow_remote)
        begin
          s_next.loc = RCA_LOC_LOCAL;
        end
        else if (!analog_req)
        begin
          s_next.loc = RCA_LOC_MANUAL;
        end
      end
      default:
      begin
        s_next.err = i_dig_req_take;
        // Analog resumes on its own; digital must ask again
        if (i_allow_remote)
        begin
          s_next.loc = analog_req ? RCA_LOC_ANALOG : RCA_LOC_MANUAL;
        end
      end
    endcase

    if (s_next.loc == RCA_LOC_ANALOG)
    begin
      // All four together, never mixed with local values
      s_next.u = clip(i_voltage_setpoint_in, i_lim_u);
      s_next.i = clip(i_current_setpoint_in, i_lim_i);
      s_next.p = clip(i_power_setpoint_in, i_lim_p);
      s_next.r = clip(i_resistance_setpoint_in, i_lim_r);
    end
    else
    begin
      // Local values still clipped, limits may drop below them
      s_next.u = clip(i_local_u, i_lim_u);
      s_next.i = clip(i_local_i, i_lim_i);
      s_next.p = clip(i_local_p, i_lim_p);
      s_next.r = clip(i_local_r, i_lim_r);
    end
    // Thresholds only from local/digital configuration
    s_next.overvoltage_protection = i_ovp_thresh;
    // Reference follows the range so set and monitor pins share one scale
    if (i_range_10v)
    begin
      s_next.vref = RCA_REF_10V;
    end
    else
    begin
      s_next.vref = RCA_REF_5V;
    end
    s_next.voltage_monitor_out = scale(i_actual_u_pct, s_next.vref);
    s_next.current_monitor_out = scale(i_actual_i_pct, s_next.vref);

    // Standby works regardless of select
    s_next.sb_prev = i_output_standby_input;
    if (!i_output_standby_input)
    begin
      // Saturates so a long standby cannot wrap into a short one
      if (s_reg.sb_low < 32'(ACK_LOW_CYC))
      begin
        s_next.sb_low = s_reg.sb_low + 32'h1;
      end
    end
    else
    begin
      s_next.sb_low = '0;
      s_next.ack = sb_rise && (s_reg.sb_low >= 32'(ACK_LOW_CYC));
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      s_reg.loc <= RCA_LOC_MANUAL;
      s_reg.ifx <= '0;
      s_reg.err <= 1'b0;
      s_reg.st_ack <= 1'b0;
      s_reg.st_loc <= 2'h0;
      s_reg.expired <= 1'b0;
      s_reg.off_req <= 1'b0;
      // Idle-high pin, so no false release edge after reset
      s_reg.sb_prev <= 1'b1;
      s_reg.sb_low <= '0;
      s_reg.ack <= 1'b0;
      s_reg.u <= '0;
      s_reg.i <= '0;
      s_reg.p <= '0;
      s_reg.r <= '0;
      s_reg.overvoltage_protection <= '0;
      s_reg.vref <= RCA_REF_5V;
      s_reg.voltage_monitor_out <= '0;
      s_reg.current_monitor_out <= '0;
    end
    else if (i_ce)
    begin
      s_reg <= s_next;
    end
  end

  // Network connection timeout lives elsewhere; nothing here cancels it
  assign o_location = s_reg.loc;
  assign o_ctrl_if = s_reg.ifx;
  assign o_dig_error = s_reg.err;
  assign o_dig_status_ack = s_reg.st_ack;
  assign o_dig_status_loc = s_reg.st_loc;
  assign o_sup_expired = s_reg.expired;
  assign o_output_off_req = s_reg.off_req;
  assign o_alarm_ack = s_reg.ack;
  // Applied values and analog pins
  assign o_set_u = s_reg.u;
  assign o_set_i = s_reg.i;
  assign o_set_p = s_reg.p;
  assign o_set_r = s_reg.r;
  assign o_ovp_applied = s_reg.overvoltage_protection;
  assign o_vref = s_reg.vref;
  assign o_voltage_monitor_out = s_reg.voltage_monitor_out;
  assign o_current_monitor_out = s_reg.current_monitor_out;
endmodule

// ---- tb/rca_arbiter_checker.sv ----
`timescale 1ns/100ps
module rca_arbiter_checker
(
  // Clock, reset, settings
  input wire logic i_ref_clk,
  input wire logic i_resetn,
  input wire logic i_ce,
  input wire logic i_allow_remote,
  input wire logic i_range_10v,
  // Requests
  input wire logic i_dig_req_take,
  input wire logic i_dig_status_rd,
  input wire logic i_remote_select_n,
  // Results
  input wire logic [1:0] o_location,
  input wire logic o_dig_error,
  input wire logic o_dig_status_ack,
  input wire logic o_sup_expired,
  input wire logic [rca_pkg::RCA_VAL_W-1:0] o_vref
);
  import rca_pkg::*;
  default clocking @(posedge i_ref_clk);
  endclocking
  default disable iff (!i_resetn);
  sequence s_lock_exit;
    o_location == 2'h3 && i_allow_remote && i_ce;
  endsequence
  sequence s_to_manual;
    ##[0:1] o_location == 2'h0;
  endsequence
  a_lockout_local: assert property (i_ce && !i_allow_remote |=> o_location == 2'h3)
    else $error("lockout not entered");
  a_take_refused: assert property (i_ce && i_dig_req_take && o_location[1] |=> o_dig_error)
    else $error("take not refused");
  a_lock_exit: assert property (s_lock_exit |=> o_location == ($past(i_remote_select_n) ? 2'h0 : 2'h2))
    else $error("bad lockout exit");
  a_select_ignored: assert property (i_ce && o_location == 2'h1 && i_allow_remote |=> o_location != 2'h2)
    else $error("select not ignored");
  a_analog_take: assert property (i_ce && o_location == 2'h0 && i_allow_remote && !i_remote_select_n
    && !i_dig_req_take |=> o_location == 2'h2)
    else $error("analog not taken");
  a_status_answer: assert property (i_ce && i_dig_status_rd |=> o_dig_status_ack)
    else $error("status not answered");
  a_expiry_exit: assert property (o_sup_expired |-> s_to_manual)
    else $error("expiry kept remote");
  a_sup_scope: assert property (o_sup_expired |-> $past(o_location) == 2'h1)
    else $error("expiry outside digital");
  a_vref_range: assert property (i_ce |=> o_vref == ($past(i_range_10v) ? RCA_REF_10V : RCA_REF_5V))
    else $error("bad reference");
endmodule
bind rca_arbiter rca_arbiter_checker u_rca_arbiter_checker (.*);

// ---- tb/rca_host_model.sv ----
`timescale 1ns/100ps
module rca_host_model
#(
  parameter int GAP = 10
)
(
  // Clock and enable
  input wire logic i_ref_clk,
  input wire logic i_en,
  // Message strobe
  output logic o_msg = 1'b0
);
  int cnt = 0;
  // Gap stays well inside the timeout so the link looks healthy
  always @(posedge i_ref_clk)
  begin
    cnt <= (cnt == GAP - 1) ? 0 : cnt + 1;
    o_msg <= i_en && (cnt == 0);
  end
endmodule

// ---- tb/testbench.sv ----
`timescale 1ns/100ps
module testbench;
  import rca_pkg::*;
  logic i_ref_clk = 1'b0, i_resetn = 1'b0, i_ce = 1'b1, host_en = 1'b0, i_dig_msg, s, o, a;
  logic i_allow_remote = 1'b1, i_state_after_remote_on = 1'b0, i_range_10v = 1'b0, i_output_on = 1'b1;
  logic i_dig_req_take = 1'b0, i_dig_req_release = 1'b0, i_dig_status_rd = 1'b0;
  logic i_remote_select_n = 1'b1, i_output_standby_input = 1'b1;
  logic [1:0] i_dig_if = 2'h0, i_dig_status_if = 2'h1, i_dig_msg_if = 2'h3, o_location, o_dig_status_loc, o_ctrl_if;
  logic [15:0] i_sup_timeout = 16'h0005, i_voltage_setpoint_in = 16'h3000, i_current_setpoint_in = 16'h0100;
  logic [15:0] i_power_setpoint_in = 16'h0200, i_resistance_setpoint_in = 16'h0300, i_ovp_thresh = 16'h1234;
  logic [15:0] i_local_u = 16'h0555, i_local_i = 16'h0555, i_local_p = 16'h0555, i_local_r = 16'h0555;
  logic [15:0] i_lim_u = 16'h2000, i_lim_i = 16'hFFFF, i_lim_p = 16'hFFFF, i_lim_r = 16'hFFFF;
  logic [15:0] i_actual_u_pct = 16'h8000, i_actual_i_pct = 16'h4000;
  logic o_dig_error, o_dig_status_ack, o_sup_expired, o_output_off_req, o_alarm_ack;
  logic [15:0] o_set_u, o_set_i, o_set_p, o_set_r, o_ovp_applied, o_vref, o_voltage_monitor_out, o_current_monitor_out;
  int num_errors = 0, compares = 0, cycles = 0;
  rca_arbiter #(.TICK_CYC(4), .ACK_LOW_CYC(10)) u_rca_arbiter (.*);
  rca_host_model u_rca_host_model (.i_ref_clk(i_ref_clk), .i_en(host_en), .o_msg(i_dig_msg));
  always #12.5 i_ref_clk = ~i_ref_clk;
  task automatic end_sim;
    $display("compares %0d num_errors %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  always @(posedge i_ref_clk)
  begin
    cycles++;
    if (cycles == 2000)
    begin
      num_errors++;
      end_sim();
    end
  end
  task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    compares++;
    if (got !== exp)
    begin
      num_errors++;
      $display("BAD %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge i_ref_clk);
    #1;
  endtask
  // Pulses collected over a window, since their exact cycle is not pinned down
  task automatic watch(input int n);
    s = 1'b0;
    o = 1'b0;
    a = 1'b0;
    repeat (n)
    begin
      cyc(1);
      s |= o_sup_expired;
      o |= o_output_off_req;
      a |= o_alarm_ack;
    end
  endtask
  task automatic take(input logic [1:0] ifx);
    @(posedge i_ref_clk);
    i_dig_req_take <= 1'b1;
    i_dig_if <= ifx;
    @(posedge i_ref_clk);
    i_dig_req_take <= 1'b0;
    #1;
  endtask
  task automatic t_digital;
    take(2'h3);
    chk("ctrl_if", 2'h3, o_ctrl_if);
    @(posedge i_ref_clk);
    i_dig_status_rd <= 1'b1;
    @(posedge i_ref_clk);
    i_dig_status_rd <= 1'b0;
    #1;
    chk("status_loc", 2'h1, o_dig_status_loc);
    chk("status_ack", 1'b1, o_dig_status_ack);
    @(posedge i_ref_clk);
    host_en <= 1'b1;
    i_remote_select_n <= 1'b0;
    cyc(60);
    chk("loc_kept", 2'h1, o_location);
    @(posedge i_ref_clk);
    host_en <= 1'b0;
    watch(40);
    chk("expired", 1'b1, s);
    chk("off_req", 1'b1, o);
    chk("no_ack_dig", 1'b0, a);
  endtask
  task automatic t_analog;
    chk("loc_analog", 2'h2, o_location);
    chk("set_u", 16'h2000, o_set_u);
    chk("set_p", 16'h0200, o_set_p);
    chk("set_i", 16'h0100, o_set_i);
    chk("set_r", 16'h0300, o_set_r);
    chk("ovp", 16'h1234, o_ovp_applied);
    chk("vmon5", 16'h09C4, o_voltage_monitor_out);
    @(posedge i_ref_clk);
    i_range_10v <= 1'b1;
    i_lim_u <= 16'h4000;
    cyc(3);
    chk("set_u_hi", 16'h3000, o_set_u);
    chk("vref10", 16'h2710, o_vref);
    chk("cmon10", 16'h09C4, o_current_monitor_out);
    take(2'h1);
    chk("err_analog", 1'b1, o_dig_error);
  endtask
  task automatic lock(input logic v, input logic sel);
    @(posedge i_ref_clk);
    i_allow_remote <= v;
    i_remote_select_n <= sel;
    cyc(3);
  endtask
  task automatic t_lockout;
    lock(1'b0, 1'b0);
    chk("loc_local", 2'h3, o_location);
    take(2'h0);
    chk("err_local", 1'b1, o_dig_error);
    lock(1'b1, 1'b0);
    chk("resume", 2'h2, o_location);
    lock(1'b1, 1'b1);
    chk("manual", 2'h0, o_location);
    chk("set_u_loc", 16'h0555, o_set_u);
    take(2'h0);
    chk("loc_dig", 2'h1, o_location);
    take(2'h2);
    chk("err_other", 1'b1, o_dig_error);
    lock(1'b0, 1'b1);
    lock(1'b1, 1'b1);
    chk("no_resume", 2'h0, o_location);
  endtask
  task automatic t_standby(input int low, input logic exp);
    @(posedge i_ref_clk);
    i_output_standby_input <= 1'b0;
    cyc(low);
    @(posedge i_ref_clk);
    i_output_standby_input <= 1'b1;
    watch(4);
    chk("alarm_ack", exp, a);
    chk("no_expiry", 1'b0, s);
  endtask
  initial
  begin
    repeat (8) @(posedge i_ref_clk);
    i_resetn <= 1'b1;
    // Outputs are not judged until the block is out of reset
    cyc(1);
    chk("vref_rst", 16'h1388, o_vref);
    t_digital();
    t_analog();
    t_lockout();
    t_standby(5, 1'b0);
    t_standby(12, 1'b1);
    end_sim();
  end
endmodule
